// File: adcsq_regs.svh
// Register offsets, field positions, reset values and timing counts
// for the conversion sequencer. Included by the core and the test bench.
`ifndef ADCSQ_REGS_SVH
`define ADCSQ_REGS_SVH

// ----------------------------------------------------------------
// Byte offsets on the register bus
// ----------------------------------------------------------------
`define ADCSQ_OFF_CTRL 4'h0
`define ADCSQ_OFF_CFG 4'h4
`define ADCSQ_OFF_RESULT 4'h8
`define ADCSQ_OFF_STATUS 4'hc
`define ADCSQ_OFF_PORT 4'h0
`define ADCSQ_ADDR_BITS 5
`define ADCSQ_PORT_PAGE 1'b1

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ADCSQ_CTRL_POWER 0
`define ADCSQ_CTRL_GO 2
`define ADCSQ_CTRL_CHAN_LSB 3
`define ADCSQ_CTRL_CKLO_LSB 6
`define ADCSQ_CFG_PCFG_LSB 0
`define ADCSQ_CFG_CKHI 6
`define ADCSQ_CFG_FMT 7
`define ADCSQ_CFG_WAKE_EN 8
`define ADCSQ_ST_FLAG 0
`define ADCSQ_ST_BUSY 1
`define ADCSQ_ST_OFF 2

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define ADCSQ_CTRL_RST 8'h00
`define ADCSQ_CFG_RST 9'h000
`define ADCSQ_RESULT_RST 16'h0000
`define ADCSQ_TCY_TOSC 3'h4
`define ADCSQ_TAD_PER_CONV 4'hc
`define ADCSQ_RC_CODE 2'h3

`endif

// File: adcsq_pkg.sv
// Types shared by the conversion sequencer and its surroundings.
// Assumes adcsq_regs.svh sits in the same folder.
package adcsq_pkg;

    typedef enum logic [1:0] {
        ADCSQ_IDLE = 2'b00,
        ADCSQ_DELAY = 2'b01,
        ADCSQ_CONV = 2'b10
    } adcsq_state_t;

    // Drive toward the analog multiplexer, hold capacitor and DAC.
    typedef struct packed {
        logic sample_on;
        logic [2:0] channel;
        logic [9:0] trial;
    } adcsq_ana_t;

endpackage

// File: adcsq_core.sv
// Conversion sequencer for a 10-bit successive-approximation converter,
// with its control, result and port registers on an AXI4-Lite slave.
// Assumes aclk is the oscillator clock, the comparator answer is
// synchronous to aclk, and the RC oscillator and port pins are async.
//
// Behaviour
// - Twelve bit periods per conversion, stepped on tad.
// - Clock select code picks divider or RC.
// - Hold capacitor is never discharged.
// - Convert regardless of pin direction settings.
// - Analog pins read zero from port register.
// - Clearing go aborts, no partial result.
// - Result keeps last completed or written value.
// - After abort, acquire again, accept new go.
// - First segment between one instruction cycle, tad.
// - Result justified into sixteen bits, zero fill.
// - Result bytes are plain storage when off.
// - RC clock delays start one instruction cycle.
// - Sleep completion on RC clears go, loads.
// - Sleep on non-RC clock aborts, power reads set.
// - Completion loads result, clears go, sets flag.
// - Format bit one right, zero left justified.
// - Reset powers off and aborts conversion.
//
// The AXI4-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`include "adcsq_regs.svh"

module adcsq_core (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [`ADCSQ_ADDR_BITS-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`ADCSQ_ADDR_BITS-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic rc_osc_in,
    input wire logic [7:0] port_pins_in,
    input wire logic comparator_hi,
    input wire logic sleep_active,
    output adcsq_pkg::adcsq_ana_t ana,
    output logic conversion_complete_flag,
    output logic wake_pulse
);
    import adcsq_pkg::*;

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    // Oscillator periods per bit period, minus one.
    function automatic logic [6:0] tad_last(input logic [2:0] sel);
        unique case (sel)
            3'b000: tad_last = 7'h01;
            3'b100: tad_last = 7'h03;
            3'b001: tad_last = 7'h07;
            3'b101: tad_last = 7'h0f;
            3'b010: tad_last = 7'h1f;
            3'b110: tad_last = 7'h3f;
            default: tad_last = 7'h01;
        endcase
    endfunction

    // Pins that the port configuration makes analog inputs.
    function automatic logic [7:0] analog_mask(input logic [3:0] pcfg);
        unique case (pcfg)
            4'h0: analog_mask = 8'hff;
            4'h1: analog_mask = 8'hf7;
            4'h2: analog_mask = 8'h1f;
            4'h3: analog_mask = 8'h17;
            4'h4: analog_mask = 8'h0b;
            4'h5: analog_mask = 8'h03;
            4'h6, 4'h7: analog_mask = 8'h00;
            4'h8: analog_mask = 8'hf3;
            4'h9: analog_mask = 8'h3f;
            4'ha: analog_mask = 8'h37;
            4'hb: analog_mask = 8'h33;
            4'hc: analog_mask = 8'h13;
            4'hd: analog_mask = 8'h03;
            4'he: analog_mask = 8'h01;
            4'hf: analog_mask = 8'h01;
        endcase
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    adcsq_state_t state_q;
    logic power_q, go_q, ckhi_q, fmt_q, wake_en_q, flag_q, off_q;
    logic [2:0] chan_q;
    logic [1:0] cklo_q;
    logic [3:0] pcfg_q;
    logic [15:0] res_q;
    logic [6:0] div_q;
    logic [3:0] seg_q;
    logic [2:0] cyc_q;
    logic [9:0] code_q;
    logic [2:0] rc_s;
    logic rc_q;
    logic [7:0] pin_s1, pin_s2, pin_s3, pin_q;
    logic aw_full_q, w_full_q;
    logic [`ADCSQ_ADDR_BITS-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    // The RC level is taken only once the second and third stages agree, so a
    // metastable first stage never reaches it; a port pin reads low while they differ.
    always_ff @(posedge aclk) begin
        rc_s <= {rc_s[1:0], rc_osc_in};
        pin_s1 <= port_pins_in;
        pin_s2 <= pin_s1;
        pin_s3 <= pin_s2;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rc_q <= 1'b0;
            pin_q <= 8'h00;
        end else begin
            if (rc_s[2] == rc_s[1]) begin
                rc_q <= rc_s[2];
            end
            pin_q <= (pin_q & ~(pin_s2 ^ pin_s3)) | (pin_s3 & ~(pin_s2 ^ pin_s3));
        end
    end

    // ------------------------------------------------------------
    // Register bus decode
    // ------------------------------------------------------------
    wire wr_fire = aw_full_q && w_full_q && !s_axi_bvalid;
    wire rd_fire = s_axi_arvalid && s_axi_arready;
    wire wr_page = awaddr_q[`ADCSQ_ADDR_BITS-1];
    wire [3:0] wr_off = awaddr_q[3:0];
    wire wr_ctrl = wr_fire && !wr_page && wr_off == `ADCSQ_OFF_CTRL;
    wire wr_cfg = wr_fire && !wr_page && wr_off == `ADCSQ_OFF_CFG;
    wire wr_res = wr_fire && !wr_page && wr_off == `ADCSQ_OFF_RESULT;
    wire wr_stat = wr_fire && !wr_page && wr_off == `ADCSQ_OFF_STATUS;
    wire wr_port = wr_fire && wr_page && wr_off == `ADCSQ_OFF_PORT;
    wire wr_ok = wr_ctrl || wr_cfg || wr_res || wr_stat || wr_port;
    wire rd_page = s_axi_araddr[`ADCSQ_ADDR_BITS-1];
    wire [3:0] rd_off = s_axi_araddr[3:0];

    // ------------------------------------------------------------
    // Conversion control
    // ------------------------------------------------------------
    // RC source selection
    wire rc_sel = cklo_q == `ADCSQ_RC_CODE;
    wire rc_rise = rc_s[2] && rc_s[1] && !rc_q;
    wire div_end = div_q == tad_last({ckhi_q, cklo_q});
    wire tad_tick = rc_sel ? rc_rise : div_end;
    wire running = state_q != ADCSQ_IDLE;
    // go only counts when power was already on
    wire start = wr_ctrl && wstrb_q[0] && wdata_q[`ADCSQ_CTRL_GO]
        && wdata_q[`ADCSQ_CTRL_POWER] && power_q && !go_q && !off_q;
    wire sw_abort = running && wr_ctrl && wstrb_q[0]
        && !(wdata_q[`ADCSQ_CTRL_GO] && wdata_q[`ADCSQ_CTRL_POWER]);
    // sleep on a divided clock stops the conversion
    wire sleep_abort = sleep_active && !rc_sel && power_q;
    wire abort = sw_abort || (running && sleep_abort);
    // first segment lasts at least one instruction cycle
    wire first_ok = seg_q != 4'h0 || cyc_q >= `ADCSQ_TCY_TOSC - 3'h1;
    wire step = state_q == ADCSQ_CONV && tad_tick && first_ok;
    wire resolve = step && seg_q != 4'h0 && seg_q <= 4'ha;
    wire [3:0] idx = 4'ha - seg_q;
    // twelfth bit period ends the conversion
    wire done = step && seg_q == `ADCSQ_TAD_PER_CONV - 4'h1 && !abort;
    wire [15:0] justified = fmt_q ? {6'h00, code_q} : {code_q, 6'h00};

    // divider restarts on start and abort
    always_ff @(posedge aclk) begin
        if (!aresetn || start || abort || !running || div_end) begin
            div_q <= 7'h00;
        end else begin
            div_q <= div_q + 7'h01;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= ADCSQ_IDLE;
            seg_q <= 4'h0;
            cyc_q <= 3'h0;
            code_q <= 10'h000;
        end else if (abort) begin
            state_q <= ADCSQ_IDLE;
        end else if (start) begin
            // RC start waits one instruction cycle
            state_q <= rc_sel ? ADCSQ_DELAY : ADCSQ_CONV;
            seg_q <= 4'h0;
            cyc_q <= 3'h0;
            code_q <= 10'h200;
        end else if (state_q == ADCSQ_DELAY) begin
            cyc_q <= cyc_q + 3'h1;
            if (cyc_q == `ADCSQ_TCY_TOSC - 3'h1) begin
                state_q <= ADCSQ_CONV;
            end
        end else if (state_q == ADCSQ_CONV) begin
            if (cyc_q != `ADCSQ_TCY_TOSC - 3'h1) begin
                cyc_q <= cyc_q + 3'h1;
            end
            if (step) begin
                seg_q <= seg_q + 4'h1;
            end
            // one bit resolved per bit period, second to eleventh
            if (resolve) begin
                code_q[idx] <= comparator_hi;
                if (idx != 4'h0) begin
                    code_q[idx-4'h1] <= 1'b1;
                end
            end
            if (done) begin
                state_q <= ADCSQ_IDLE;
            end
        end
    end

    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {cklo_q, chan_q, go_q, power_q} <= 7'h00;
            {wake_en_q, fmt_q, ckhi_q, pcfg_q} <= 7'h00;
            flag_q <= 1'b0;
            off_q <= 1'b0;
        end else begin
            if (wr_ctrl && wstrb_q[0]) begin
                power_q <= wdata_q[`ADCSQ_CTRL_POWER];
                chan_q <= wdata_q[`ADCSQ_CTRL_CHAN_LSB +: 3];
                cklo_q <= wdata_q[`ADCSQ_CTRL_CKLO_LSB +: 2];
            end
            if (wr_cfg && wstrb_q[0]) begin
                pcfg_q <= wdata_q[`ADCSQ_CFG_PCFG_LSB +: 4];
                ckhi_q <= wdata_q[`ADCSQ_CFG_CKHI];
                fmt_q <= wdata_q[`ADCSQ_CFG_FMT];
            end
            if (wr_cfg && wstrb_q[1]) begin
                wake_en_q <= wdata_q[`ADCSQ_CFG_WAKE_EN];
            end
            // go follows start, abort and completion
            if (start) begin
                go_q <= 1'b1;
            // A go write with power set while busy is not a restart and leaves go set.
            end else if (abort || done) begin
                go_q <= 1'b0;
            end
            // flag set wins over a same-cycle clear
            if (done) begin
                flag_q <= 1'b1;
            end else if (wr_stat && wstrb_q[0]
                && wdata_q[`ADCSQ_ST_FLAG]) begin
                flag_q <= 1'b0;
            end
            // module powered down while power bit reads set
            off_q <= sleep_abort;
        end
    end

    // result changes only on completion or a write
    always_ff @(posedge aclk) begin
        if (done) begin
            res_q <= justified;
        end else if (wr_res) begin
            if (wstrb_q[0]) begin
                res_q[7:0] <= wdata_q[7:0];
            end
            if (wstrb_q[1]) begin
                res_q[15:8] <= wdata_q[15:8];
            end
        end
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    // analog pins read as zero
    wire [7:0] port_rd = pin_q & ~analog_mask(pcfg_q);
    wire [7:0] ctrl_rd = {cklo_q, chan_q, go_q, 1'b0, power_q};
    wire [8:0] cfg_rd = {wake_en_q, fmt_q, ckhi_q, 2'b00, pcfg_q};
    wire [2:0] st_rd = {off_q, running, flag_q};
    wire rd_hit = rd_page ? rd_off == `ADCSQ_OFF_PORT
        : rd_off[1:0] == 2'b00;
    wire [31:0] rd_word = rd_page ? {24'h000000, port_rd}
        : rd_off == `ADCSQ_OFF_CTRL ? {24'h000000, ctrl_rd}
        : rd_off == `ADCSQ_OFF_CFG ? {23'h000000, cfg_rd}
        : rd_off == `ADCSQ_OFF_RESULT ? {16'h0000, res_q}
        : {29'h00000000, st_rd};

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    // Address and data are held separately so either may come first;
    // unmapped offsets answer SLVERR and change nothing.
    assign s_axi_awready = !aw_full_q;
    assign s_axi_wready = !w_full_q;
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= 2'b00;
            s_axi_rdata <= 32'h00000000;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_full_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_full_q <= 1'b0;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_hit ? rd_word : 32'h00000000;
                s_axi_rresp <= rd_hit ? 2'b00 : 2'b10;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // the hold capacitor only ever samples the channel
    // nothing discharges it and pin direction is not consulted.
    wire sample_on = power_q && !off_q && state_q == ADCSQ_IDLE;
    assign ana = {sample_on, chan_q, code_q};
    assign conversion_complete_flag = flag_q;

    // wake from sleep on completion when enabled
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wake_pulse <= 1'b0;
        end else begin
            wake_pulse <= done && sleep_active && wake_en_q;
        end
    end
endmodule

// File: adcsq_checker.sv
// Port-level assertions for the conversion sequencer core.
// Assumes one clock domain and a bind onto adcsq_core.
`timescale 1ns/10ps

module adcsq_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sleep_active,
    input wire adcsq_pkg::adcsq_ana_t ana,
    input wire logic conversion_complete_flag,
    input wire logic wake_pulse
);
    import adcsq_pkg::*;

    // ----
    // Open-switch counter
    // ----
    // Saturates so a long power-off stretch cannot wrap into a short one.
    logic [7:0] open_cnt_q;
    logic [7:0] open_cnt_d;
    assign open_cnt_d = ana.sample_on ? 8'h00 :
        ((&open_cnt_q) ? open_cnt_q : open_cnt_q + 8'h01);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            open_cnt_q <= 8'h00;
        end else begin
            open_cnt_q <= open_cnt_d;
        end
    end

    // ----
    // Properties
    // ----
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_done;
        $rose(conversion_complete_flag);
    endsequence

    a_write_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write response missing");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
        else $error("read data missing");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while data pending");
    a_reset_quiet: assert property (disable iff (1'h0)
        !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !wake_pulse &&
        !conversion_complete_flag && !ana.sample_on)
        else $error("outputs active after reset");
    a_conv_length: assert property (s_done |-> open_cnt_q >= 8'd24)
        else $error("conversion shorter than twelve periods");
    a_flag_sticky: assert property ($fell(conversion_complete_flag) |->
        s_axi_bvalid && s_axi_bresp == 2'b00)
        else $error("flag cleared without a clearing write");
    a_acquire_after: assert property (s_done ##0 !sleep_active |->
        ana.sample_on)
        else $error("no acquisition after completion");
    a_wake_single: assert property (wake_pulse |=> !wake_pulse)
        else $error("wake pulse longer than one cycle");
    a_wake_sleep: assert property (wake_pulse |->
        conversion_complete_flag && (sleep_active || $past(sleep_active)))
        else $error("wake outside a sleep completion");
endmodule

bind adcsq_core adcsq_checker u_chk (.*);

// File: adc_conversion_sequencer_test.sv
// Self-checking bench for the conversion sequencer over AXI4-Lite.
// Assumes the register header, package, core and checker compile first.
`timescale 1ns/10ps
`include "adcsq_regs.svh"

module adc_conversion_sequencer_test;
    import adcsq_pkg::*;
    localparam logic [4:0] adr_ctl = {1'h0, `ADCSQ_OFF_CTRL};
    localparam logic [4:0] adr_cfg = {1'h0, `ADCSQ_OFF_CFG};
    localparam logic [4:0] adr_res = {1'h0, `ADCSQ_OFF_RESULT};
    localparam logic [4:0] adr_st = {1'h0, `ADCSQ_OFF_STATUS};
    localparam logic [4:0] adr_port = {`ADCSQ_PORT_PAGE, `ADCSQ_OFF_PORT};
    localparam logic [1:0] ok = 2'h0;
    localparam int acq_cycles = 20;
    logic aclk = 1'h0, aresetn = 1'h0, rc_osc_in = 1'h0, sleep_active = 1'h0;
    logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, ctl;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic [7:0] port_pins_in = 8'h00, pins;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, comparator_hi, conversion_complete_flag, wake_pulse;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    adcsq_ana_t ana;
    int error_cnt = 0, samples_checked = 0, seed = 32'h246e0a1b, vin = 0;
    logic rc_run = 1'h0, wake_seen = 1'h0;
    logic [3:0] pcf [6] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'h9, 4'he};
    logic [7:0] amask [6] = '{8'hff, 8'h1f, 8'h0b, 8'h00, 8'h3f, 8'h01};

    always #5 aclk = ~aclk;
    // the RC bit period is 1.6 us; it stands still outside RC runs.
    always #800 rc_osc_in = rc_run ? ~rc_osc_in : 1'h0;
    assign comparator_hi = (vin >= int'(ana.trial));
    always @(posedge aclk) if (wake_pulse === 1'h1) wake_seen <= 1'h1;

    adcsq_core u_dut (.*);

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d,
            input logic [3:0] s, input logic [1:0] er);
        logic ah, wh;
        ah = 1'h0;
        wh = 1'h0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (!(ah && wh)) begin
            @(negedge aclk);
            ah = ah | s_axi_awready;
            wh = wh | s_axi_wready;
            @(posedge aclk);
            if (ah) s_axi_awvalid <= 1'h0;
            if (wh) s_axi_wvalid <= 1'h0;
        end
        do @(negedge aclk); while (s_axi_bvalid !== 1'h1);
        chk({30'h0, s_axi_bresp}, {30'h0, er});
        // Bready stays high after the response; each write drives it high again at its start.
        @(posedge aclk);
    endtask

    // Read data is accepted one cycle late to exercise the hold rule.
    task automatic rd(input logic [4:0] a, input logic [31:0] ed,
            input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do @(negedge aclk); while (s_axi_arready !== 1'h1);
        @(posedge aclk);
        s_axi_arvalid <= 1'h0;
        @(posedge aclk);
        s_axi_rready <= 1'h1;
        do @(negedge aclk); while (s_axi_rvalid !== 1'h1);
        chk(s_axi_rdata, ed);
        chk({30'h0, s_axi_rresp}, {30'h0, er});
        @(posedge aclk);
        s_axi_rready <= 1'h0;
    endtask

    function automatic logic [31:0] justify(int v, logic f);
        return f ? {22'h0, v[9:0]} : {16'h0, v[9:0], 6'h0};
    endfunction

    task automatic start(input logic [2:0] c, input logic f, input logic wk);
        ctl = {24'h0, c[1:0], c, 3'h1};
        wr(adr_cfg, {23'h0, wk, f, c[2], 6'h0}, 4'hf, ok);
        wr(adr_ctl, ctl, 4'hf, ok);
        repeat (acq_cycles) @(posedge aclk);
        wr(adr_ctl, ctl | 32'h4, 4'hf, ok);
    endtask

    task automatic conv(input logic [2:0] c, input logic f, input logic sl);
        int n, per;
        n = 0;
        per = 2 << (2 * c[1:0] + c[2]);
        vin = $random(seed) & 32'h3ff;
        wake_seen <= 1'h0;
        rc_run = (c[1:0] == 2'h3);
        start(c, f, sl);
        sleep_active <= sl;
        while (conversion_complete_flag !== 1'h1) begin
            @(negedge aclk);
            n++;
        end
        chk({29'h0, ana.channel}, {29'h0, c});
        @(posedge aclk);
        sleep_active <= 1'h0;
        rc_run = 1'h0;
        if (c[1:0] != 2'h3) chk(32'(n + 3 >= 12 * per && n <= 12 * per + 12), 32'h1);
        rd(adr_ctl, ctl, ok);
        rd(adr_st, 32'h1, ok);
        rd(adr_res, justify(vin, f), ok);
        chk({31'h0, wake_seen}, {31'h0, sl});
        wr(adr_st, 32'h1, 4'hf, ok);
        rd(adr_st, 32'h0, ok);
    endtask

    task automatic abort_run(input logic [2:0] c, input logic by_sleep);
        logic [31:0] keep;
        keep = $random(seed) & 32'hffff;
        wr(adr_res, keep, 4'h3, ok);
        start(c, 1'h1, 1'h0);
        repeat (60) @(posedge aclk);
        if (by_sleep) begin
            sleep_active <= 1'h1;
            repeat (3) @(posedge aclk);
            rd(adr_st, 32'h4, ok);
            rd(adr_ctl, ctl, ok);
            sleep_active <= 1'h0;
        end else begin
            wr(adr_ctl, ctl, 4'hf, ok);
        end
        repeat (900) @(posedge aclk);
        @(negedge aclk);
        chk({31'h0, conversion_complete_flag}, 32'h0);
        chk({31'h0, ana.sample_on}, 32'h1);
        @(posedge aclk);
        rd(adr_res, keep, ok);
    endtask

    task automatic report_and_stop();
        $display("errors %0d checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        #300000;
        error_cnt++;
        report_and_stop();
    end

    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        rd(5'h14, 32'h0, 2'h2);
        wr(5'h18, 32'hffff, 4'hf, 2'h2);
        rd(adr_ctl, 32'h0, ok);
        wr(adr_res, 32'h1234, 4'h3, ok);
        wr(adr_res, 32'haa56, 4'h1, ok);
        rd(adr_res, 32'h1256, ok);
        for (int i = 0; i < 6; i++) begin
            pins = 8'($random(seed));
            port_pins_in <= pins;
            wr(adr_cfg, {28'h0, pcf[i]}, 4'hf, ok);
            repeat (4) @(posedge aclk);
            rd(adr_port, {24'h0, pins & ~amask[i]}, ok);
        end
        wr(adr_ctl, 32'h5, 4'hf, ok);
        repeat (40) @(posedge aclk);
        rd(adr_ctl, 32'h1, ok);
        for (int i = 0; i < 8; i++) begin
            conv(3'(i), 1'(i), 1'(i % 4 == 3));
        end
        conv(3'h3, 1'h1, 1'h1);
        abort_run(3'h6, 1'h0);
        conv(3'h6, 1'h0, 1'h0);
        abort_run(3'h1, 1'h1);
        conv(3'h1, 1'h1, 1'h0);
        start(3'h6, 1'h0, 1'h0);
        repeat (30) @(posedge aclk);
        aresetn <= 1'h0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        rd(adr_ctl, 32'h0, ok);
        rd(adr_st, 32'h0, ok);
        report_and_stop();
    end
endmodule
